// ---- rco_pkg.sv ----
`default_nettype none
// ==========================================================================
// Shared constants of the reference clock output block.
package rco_pkg;

  // ========================================================================
  // Register map, byte addresses on the APB bus.
  localparam logic [11:0] ADDR_CTRL = 12'h0000;
  localparam logic [11:0] ADDR_SRC  = 12'h0004;
  localparam int          ADDR_W    = 12;

  // ========================================================================
  // Field positions and widths.
  localparam int ENABLE_BIT = 7;
  localparam int DUTY_LSB   = 3;
  localparam int DUTY_W     = 2;
  localparam int DIV_LSB    = 0;
  localparam int DIV_W      = 3;
  localparam int SRC_LSB    = 0;
  localparam int SRC_W      = 4;

  // Reset values: enable off, duty 50 percent, undivided, system clock.
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [7:0] SRC_RESET  = 8'h00;

  // Write masks; unimplemented bits read as zero.
  localparam logic [7:0] CTRL_MASK = 8'h9F;
  localparam logic [7:0] SRC_MASK  = 8'h0F;

  // ========================================================================
  // Source select codes.
  typedef enum logic [3:0] {
    RCO_SRC_SYS    = 4'b0000,
    RCO_SRC_HFOSC  = 4'b0001,
    RCO_SRC_LFOSC  = 4'b0010,
    RCO_SRC_MFOSC  = 4'b0011,
    RCO_SRC_SECOSC = 4'b0100,
    RCO_SRC_NUMOSC = 4'b0101,
    RCO_SRC_LC1    = 4'b0110,
    RCO_SRC_LC2    = 4'b0111,
    RCO_SRC_LC3    = 4'b1000,
    RCO_SRC_LC4    = 4'b1001
  } rco_src_t;

  // Number of external (asynchronous) sources, codes 1 to 9.
  localparam int NUM_EXT_SRC = 9;
  localparam logic [3:0] SRC_LAST = 4'h9;

  // Duty codes.
  localparam logic [1:0] DUTY_0  = 2'b00;
  localparam logic [1:0] DUTY_25 = 2'b01;
  localparam logic [1:0] DUTY_50 = 2'b10;
  localparam logic [1:0] DUTY_75 = 2'b11;

  // Half-period counter width: a full period is up to 256 half ticks.
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_TWO = 9'h002;

endpackage
`default_nettype wire

// ---- rco_cfg_if.sv ----
`default_nettype none
// ==========================================================================
// Configuration and tick carrier between register file and divider.
interface rco_cfg_if;
  logic                     enable;
  logic                     start;
  logic                     run;
  logic                     tick;
  logic [rco_pkg::DIV_W-1:0]  divide_select;
  logic [rco_pkg::DUTY_W-1:0] duty_select;
  logic                     level;

  modport ctrl (
    output enable,
    output start,
    output run,
    output tick,
    output divide_select,
    output duty_select,
    input  level
  );

  modport div (
    input  enable,
    input  start,
    input  run,
    input  tick,
    input  divide_select,
    input  duty_select,
    output level
  );
endinterface
`default_nettype wire

// ---- rco_divider.sv ----
`default_nettype none
// ==========================================================================
// Divider and duty shaper, counting half periods of the chosen source.
module rco_divider (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Configuration and result.
  rco_cfg_if.div    cfg
);

  logic [rco_pkg::CNT_W-1:0] cnt_q;
  logic [rco_pkg::CNT_W-1:0] cnt_d;
  logic                      level_q;
  logic                      level_d;
  wire  [rco_pkg::CNT_W-1:0] period;
  wire  [rco_pkg::CNT_W-1:0] quarter;
  wire  [rco_pkg::CNT_W-1:0] high_len;
  wire                       undivided;

  // ========================================================================
  // Period and high time in half ticks.
  assign period    = rco_pkg::CNT_TWO << cfg.divide_select;
  assign quarter   = period >> 2;
  assign undivided = (cfg.divide_select == '0);
  // Undivided output follows the source and ignores the duty field.
  assign high_len  = undivided ? (period >> 1) :
                     (cfg.duty_select == rco_pkg::DUTY_75) ?
                       rco_pkg::CNT_W'(quarter * 3) :
                     (cfg.duty_select == rco_pkg::DUTY_50) ?
                       (period >> 1) :
                     (cfg.duty_select == rco_pkg::DUTY_25) ?
                       quarter : '0;

  // Next state: a start clears the counter so the first period is whole.
  always_comb begin
    cnt_d   = cnt_q;
    level_d = level_q;
    if (cfg.start) begin
      cnt_d   = '0;
      level_d = 1'b0;
    end else if (!cfg.enable) begin
      cnt_d   = '0;
      level_d = 1'b0;
    end else if (cfg.run && cfg.tick) begin
      level_d = (cnt_q < high_len);
      cnt_d   = (cnt_q + 1'b1 >= period) ? '0 : cnt_q + 1'b1;
    end
  end

  // Counter and output level; frozen while clock enable is low.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign cfg.level = level_q;

endmodule
`default_nettype wire

// ---- rco_top.sv ----
`default_nettype none
// ==========================================================================
// Reference clock output: source select, power-of-two divider, duty.
// Operation
// - Four-bit field selects the input clock source.
// - Codes: oscillators, numeric oscillator, logic cells, reserved.
// - Enabling starts output cleanly, no runt pulse.
// - Clearing enable stops output immediately.
// - Three-bit field divides by one to 128.
// - Two-bit duty field: 0, 25, 50, 75 percent.
// - Undivided setting ignores duty, passes base clock.
// - Reset gives duty 50 percent, rest zero.
// - Change divider or duty only while disabled.
// - Sleep holds outputs at present level.
// - Output drives pin and internal peripheral input.
// - Control and source register bit layout fixed.
module rco_top (
  // Clock, reset and clock enable.
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rco_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Clock sources from other domains, codes 1 to 9 in order.
  input  wire logic [rco_pkg::NUM_EXT_SRC-1:0] src_clk_in,
  // Device sleep.
  input  wire logic                        sleep,
  // Reference clock outputs.
  output logic                             ref_clock_out_pin,
  output logic                             ref_clock_to_peripherals
);

  // ========================================================================
  // Declarations.
  rco_cfg_if cfg ();

  logic [7:0]  ctrl_q;
  logic [7:0]  src_q;
  logic [31:0] rdata_q;
  logic        en_prev_q;
  logic [rco_pkg::NUM_EXT_SRC-1:0] sync1_q;
  logic [rco_pkg::NUM_EXT_SRC-1:0] sync2_q;
  logic [rco_pkg::NUM_EXT_SRC-1:0] sync3_q;
  logic [rco_pkg::NUM_EXT_SRC-1:0] stable_q;
  logic [rco_pkg::NUM_EXT_SRC-1:0] ext_tick;

  wire         setup_phase;
  wire         access_phase;
  wire         hit_ctrl;
  wire         hit_src;
  wire         unmapped;
  wire         wr_ctrl;
  wire         wr_src;
  wire  [7:0]  rd_mux;
  wire  [3:0]  src_code;
  wire         src_valid;
  wire         sel_tick;
  wire         ref_enable;

  // ========================================================================
  // APB decode: zero wait states, error on unmapped addresses.
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_ctrl     = (paddr == rco_pkg::ADDR_CTRL);
  assign hit_src      = (paddr == rco_pkg::ADDR_SRC);
  assign unmapped     = !hit_ctrl && !hit_src;
  assign wr_ctrl      = access_phase && pwrite && hit_ctrl && pstrb[0];
  assign wr_src       = access_phase && pwrite && hit_src && pstrb[0];
  assign pready       = 1'b1;
  assign pslverr      = access_phase && unmapped;
  assign prdata       = rdata_q;

  // Read mux; unimplemented bits come back as zero.
  assign rd_mux = hit_ctrl ? (ctrl_q & rco_pkg::CTRL_MASK) :
                  hit_src  ? (src_q & rco_pkg::SRC_MASK) : 8'h00;

  // Read data is captured in the setup cycle and shown in the access.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en && setup_phase) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // ========================================================================
  // Configuration registers. Divider and duty may be rewritten while
  // enabled; the output may then glitch, so software should not.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= rco_pkg::CTRL_RESET;
      src_q  <= rco_pkg::SRC_RESET;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[7:0] & rco_pkg::CTRL_MASK;
      end
      if (wr_src) begin
        src_q <= pwdata[7:0] & rco_pkg::SRC_MASK;
      end
    end
  end

  // ========================================================================
  // Source synchronisers: three stages, a change counts once the second
  // and third stages agree. Each counted change is one half tick.
  genvar g;
  generate
    for (g = 0; g < rco_pkg::NUM_EXT_SRC; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sync1_q[g]  <= 1'b0;
          sync2_q[g]  <= 1'b0;
          sync3_q[g]  <= 1'b0;
          stable_q[g] <= 1'b0;
        end else if (clk_en) begin
          sync1_q[g] <= src_clk_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            stable_q[g] <= sync3_q[g];
          end
        end
      end
      assign ext_tick[g] = (sync2_q[g] == sync3_q[g]) &&
                           (sync3_q[g] != stable_q[g]);
    end
  endgenerate

  // ========================================================================
  // Source selection. The system clock gives a half tick every cycle;
  // reserved codes give none, so the output holds.
  assign src_code  = src_q[rco_pkg::SRC_LSB +: rco_pkg::SRC_W];
  assign src_valid = (src_code <= rco_pkg::SRC_LAST);
  assign sel_tick  = (src_code == rco_pkg::RCO_SRC_SYS) ? 1'b1 :
                     src_valid ?
                       ext_tick[4'(src_code - 4'h1)] : 1'b0;

  // ========================================================================
  // Enable edge detect for the clean start.
  assign ref_enable = ctrl_q[rco_pkg::ENABLE_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      en_prev_q <= 1'b0;
    end else if (clk_en) begin
      en_prev_q <= ref_enable;
    end
  end

  // Drive the divider through the carrier; sleep freezes it in place.
  assign cfg.enable        = ref_enable;
  assign cfg.start         = ref_enable && !en_prev_q;
  assign cfg.run           = !sleep;
  assign cfg.tick          = sel_tick;
  assign cfg.divide_select = ctrl_q[rco_pkg::DIV_LSB +: rco_pkg::DIV_W];
  assign cfg.duty_select   = ctrl_q[rco_pkg::DUTY_LSB +: rco_pkg::DUTY_W];

  rco_divider u_divider (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .cfg     (cfg)
  );

  // ========================================================================
  // Output gated by the enable register so disabling cuts it at once.
  assign ref_clock_out_pin        = cfg.level && ref_enable;
  assign ref_clock_to_peripherals = cfg.level && ref_enable;

endmodule
`default_nettype wire

// ---- rco_monitor.sv ----
`default_nettype none
// ==========================================================================
// Port checks on the reference clock output block.
module rco_monitor (
  // Clock, reset and clock enable.
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clk_en,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources, sleep and outputs.
  input wire logic [8:0]  src_clk_in,
  input wire logic        sleep,
  input wire logic        ref_clock_out_pin,
  input wire logic        ref_clock_to_peripherals
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Decoded APB access events.
  wire logic acc     = psel && penable && clk_en;
  wire logic rd_ctrl = acc && !pwrite && paddr == rco_pkg::ADDR_CTRL;
  wire logic rd_src  = acc && !pwrite && paddr == rco_pkg::ADDR_SRC;
  wire logic ctrl_wr = acc && pwrite && pstrb[0]
                       && paddr == rco_pkg::ADDR_CTRL;
  wire logic mapped  = paddr == rco_pkg::ADDR_CTRL
                       || paddr == rco_pkg::ADDR_SRC;

  // Last enable value written, to tell a start from a rewrite.
  logic en_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) en_q <= 1'b0;
    else if (ctrl_wr) en_q <= pwdata[7];
  end

  sequence s_start;
    ctrl_wr && pwdata[7] && !en_q;
  endsequence
  sequence s_stop;
    ctrl_wr && !pwdata[7];
  endsequence

  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED_ERR: assert property (acc |-> pslverr == !mapped)
    else $error("error response does not match the address");
  AST_UPPER_ZERO: assert property (
    acc && !pwrite |-> prdata[31:8] == 0)
    else $error("read data above the low byte not zero");
  AST_CTRL_GAPS: assert property (rd_ctrl |-> prdata[6:5] == 2'h0)
    else $error("unused control bits read nonzero");
  AST_SRC_GAPS: assert property (rd_src |-> prdata[7:4] == 4'h0)
    else $error("unused source bits read nonzero");
  AST_STOP_NOW: assert property (s_stop |=> !ref_clock_out_pin)
    else $error("output still high after disable");
  AST_START_LOW: assert property (s_start |=> !ref_clock_out_pin [*2])
    else $error("output high before first period");
  AST_SAME_OUT: assert property (
    ref_clock_out_pin == ref_clock_to_peripherals)
    else $error("pin and peripheral clocks differ");
  AST_FREEZE: assert property ((sleep || !clk_en) && !ctrl_wr
    |=> $stable(ref_clock_out_pin))
    else $error("output moved while frozen");
endmodule

bind rco_top rco_monitor mon_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_clk_in(src_clk_in), .sleep(sleep),
  .ref_clock_out_pin(ref_clock_out_pin),
  .ref_clock_to_peripherals(ref_clock_to_peripherals)
);
`default_nettype wire

// ---- rco_partner.sv ----
`default_nettype none
// ==========================================================================
// Far side: source clocks in, measuring consumer of the reference clock.
module rco_partner (
  // Clock, reset and measurement clear.
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  input  wire logic  clr,
  input  wire logic  ref_pin,
  // Sources and measured figures.
  output logic [8:0] src_clk,
  output logic [8:0] hi_len,
  output logic [8:0] per_len,
  output logic [8:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] hi_q, per_q;
  logic [7:0] cnt_q [9];
  logic       prev_q;
  wire logic  rise = ref_pin && !prev_q;
  wire logic  fall = !ref_pin && prev_q;

  // Source i toggles every i+4 cycles; high and period lengths latched.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_clk <= 9'h000;
      {hi_q, per_q, hi_len, per_len, rises, prev_q} <= '0;
      for (int i = 0; i < 9; i++) cnt_q[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 9; i++) begin
        cnt_q[i] <= (cnt_q[i] == 8'(i + 3)) ? 8'h00 : cnt_q[i] + 8'h01;
        if (cnt_q[i] == 8'(i + 3)) src_clk[i] <= !src_clk[i];
      end
      prev_q <= ref_pin;
      hi_q <= rise ? 9'h001 : hi_q + 9'h001;
      per_q <= rise ? 9'h001 : per_q + 9'h001;
      if (clr) {hi_len, per_len, rises} <= '0;
      else begin
        if (rise) per_len <= per_q;
        if (rise) rises <= rises + 9'h001;
        if (fall) hi_len <= hi_q;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rco_top_tb.sv ----
`default_nettype none
// ==========================================================================
// Bench for the reference clock output block.
module rco_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, clk_en, psel, penable, pwrite, sleep, clr;
  logic        pready, pslverr, pin, periph, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [8:0]  src, hi, per, rises;
  int          fails, checked;
  localparam logic [11:0] CT = rco_pkg::ADDR_CTRL;
  localparam logic [11:0] SR = rco_pkg::ADDR_SRC;

  rco_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_clk_in(src), .sleep(sleep),
    .ref_clock_out_pin(pin), .ref_clock_to_peripherals(periph));
  rco_partner peer_u (.clk_sys(clk_sys), .rst_b(rst_b), .clr(clr),
    .ref_pin(pin), .src_clk(src), .hi_len(hi), .per_len(per),
    .rises(rises));

  // Clock generator.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end

  task automatic report_and_stop;
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Enable with a setting, measure the output, then disable.
  // A set f also counts the rises, which proves a whole first period.
  task automatic run(input logic [7:0] c, input int h, p, n,
                     input bit f);
    apb(1'b1, CT, 32'(c));
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    if (h == 0) chk(rises, 0);
    else begin
      chk(hi, h);
      chk(per, p);
      if (f) chk(rises, (n - 2) / p + 1);
    end
    apb(1'b1, CT, 32'(c & 8'h7F));
    #1;
    chk(pin, 0);
    chk(periph, 0);
  endtask

  initial begin
    {psel, penable, pwrite, sleep, clr, rst_b} = '0;
    clk_en = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, CT, 0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, SR, 0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, CT, 32'h0000_007F);
    apb(1'b0, CT, 0);
    chk(rd, 32'h0000_001F);
    apb(1'b1, SR, 32'h0000_00FF);
    apb(1'b0, SR, 0);
    chk(rd, 32'h0000_000F);
    apb(1'b0, 12'h008, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, SR, 0);
    // Every divide and duty setting on the system clock.
    for (int d = 0; d < 8; d++)
      for (int c = 0; c < 4; c++)
        run({3'b100, c[1:0], d[2:0]}, d == 0 ? 1 : c * (2 << d) / 4,
            2 << d, 3 * (2 << d) + 20, 1'b1);
    // Each source undivided, then a reserved code.
    for (int s = 1; s < 10; s++) begin
      apb(1'b1, SR, 32'(s));
      run(8'h90, s + 3, 2 * (s + 3), 80, 1'b0);
    end
    apb(1'b1, SR, 32'h0000_000A);
    run(8'h90, 0, 0, 40, 1'b0);
    apb(1'b1, SR, 0);
    apb(1'b1, CT, 32'h0000_0091);
    // Freeze by sleep, then by clock enable low.
    for (int i = 0; i < 2; i++) begin
      repeat (10) @(posedge clk_sys);
      {sleep, clk_en, clr} <= {i == 0, i == 0, 1'b1};
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      chk(rises, 0);
      {sleep, clk_en} <= 2'b01;
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
